// file: core/hpi_consts.svh
// Timing constants and counts for the host link initialisation block
`ifndef HPI_CONSTS_SVH
`define HPI_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define HPI_CLK_PS 4000

// ----------------------------------------------------------------------------
// Out-of-band bursts
// ----------------------------------------------------------------------------
`define HPI_BURST_PS 106700
`define HPI_RESET_GAP_PS 320000
`define HPI_WAKE_GAP_PS 106700
`define HPI_BURSTS_PER_GROUP 6
`define HPI_BURST_CYC ((`HPI_BURST_PS + `HPI_CLK_PS - 1) / `HPI_CLK_PS)
`define HPI_RESET_GAP_CYC ((`HPI_RESET_GAP_PS + `HPI_CLK_PS - 1) / `HPI_CLK_PS)
`define HPI_WAKE_GAP_CYC ((`HPI_WAKE_GAP_PS + `HPI_CLK_PS - 1) / `HPI_CLK_PS)

// ----------------------------------------------------------------------------
// Align wait
// ----------------------------------------------------------------------------
`define HPI_DWORD_PS 26667
`define HPI_DWORD_CYC ((`HPI_DWORD_PS + `HPI_CLK_PS - 1) / `HPI_CLK_PS)
`define HPI_ALIGN_TIMEOUT_US 880
`define HPI_ALIGN_TIMEOUT_DWORDS 32768
`define HPI_ALIGN_BLANK_PS 116300
`define HPI_ALIGN_BLANK_CYC ((`HPI_ALIGN_BLANK_PS + `HPI_CLK_PS - 1) / `HPI_CLK_PS)
`define HPI_NON_ALIGN_RUN 3
`define HPI_NUM_RATES 3

`endif

// file: core/hpi_pkg.sv
// Types shared by the host link initialisation block
package hpi_pkg;

  typedef enum logic [3:0] {
    HOST_RESET_STATE = 4'h0,
    HOST_WAIT_INIT_STATE = 4'h1,
    HOST_WAIT_INIT_RELEASE_STATE = 4'h2,
    HOST_CALIBRATE_STATE = 4'h3,
    HOST_SEND_WAKE_STATE = 4'h4,
    HOST_WAIT_WAKE_STATE = 4'h5,
    HOST_WAIT_WAKE_RELEASE_STATE = 4'h6,
    HOST_WAIT_ALIGN_STATE = 4'h7,
    HOST_SPEED_ADJUST_STATE = 4'h8,
    HOST_SEND_ALIGN_STATE = 4'h9,
    HOST_READY_STATE = 4'ha
  } hpi_state_e;

  typedef enum logic [1:0] {
    BURST_IDLE = 2'h0,
    BURST_ON = 2'h1,
    BURST_GAP = 2'h2
  } hpi_burst_e;

endpackage : hpi_pkg

// file: core/hpi_oob_burst.sv
// Out-of-band burst sequencer sending whole groups of six bursts
`timescale 1ns/100ps
`include "hpi_consts.svh"

module hpi_oob_burst import hpi_pkg::*; #(
  parameter int GAP_CYC = 80
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic hold,
  // Status
  output logic burst_on,
  output logic busy,
  output logic done
);

  localparam logic [7:0] BurstLast = 8'(`HPI_BURST_CYC - 1);
  localparam logic [7:0] GapLast = 8'(GAP_CYC - 1);
  localparam logic [2:0] GroupLast = 3'(`HPI_BURSTS_PER_GROUP - 1);

  hpi_burst_e st_q;
  logic [7:0] cyc_q;
  logic [2:0] num_q;

  // --------------------------------------------------------------------------
  // Sequencer: stops only at a group boundary with hold low
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    done <= 1'b0;
    if (rst) begin
      st_q <= BURST_IDLE;
      cyc_q <= 8'h00;
      num_q <= 3'h0;
    end else begin
      case (st_q)
        BURST_IDLE: begin
          if (start) begin
            st_q <= BURST_ON;
            cyc_q <= 8'h00;
            num_q <= 3'h0;
          end
        end
        BURST_ON: begin
          if (cyc_q == BurstLast) begin
            st_q <= BURST_GAP;
            cyc_q <= 8'h00;
          end else begin
            cyc_q <= cyc_q + 8'h01;
          end
        end
        BURST_GAP: begin
          if (cyc_q != GapLast) begin
            cyc_q <= cyc_q + 8'h01;
          end else if (num_q == GroupLast && !hold) begin
            st_q <= BURST_IDLE;
            done <= 1'b1;
          end else begin
            st_q <= BURST_ON;
            cyc_q <= 8'h00;
            num_q <= (num_q == GroupLast) ? 3'h0 : num_q + 3'h1;
          end
        end
        default: st_q <= BURST_IDLE;
      endcase
    end
  end

  assign burst_on = (st_q == BURST_ON);
  assign busy = (st_q != BURST_IDLE);

endmodule : hpi_oob_burst

// file: core/hpi_init_fsm.sv
// Host link initialisation state machine from reset up to link ready
`timescale 1ns/100ps
`include "hpi_consts.svh"

module hpi_init_fsm import hpi_pkg::*; #(
  parameter int ALIGN_TIMEOUT_DWORDS = `HPI_ALIGN_TIMEOUT_DWORDS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link and application controls
  input wire logic por_active,
  input wire logic reset_request,
  input wire logic retry_disable,
  input wire logic cal_enable,
  input wire logic prim_valid,
  input wire logic prim_non_align,
  // Receiver and analog pins
  input wire logic cominit_det_pin,
  input wire logic comwake_det_pin,
  input wire logic comma_det_pin,
  input wire logic cal_done_pin,
  input wire logic speed_done_pin,
  // Transmit controls
  output logic tx_comreset_burst,
  output logic tx_comwake_burst,
  output logic tx_filler,
  output logic tx_low_rate,
  output logic tx_align,
  output logic cal_start,
  output logic speed_adjust,
  // Status
  output logic [1:0] rx_rate_sel,
  output logic link_ready,
  output logic link_failed,
  output logic [3:0] state_out
);

  localparam logic [2:0] DwordLast = 3'(`HPI_DWORD_CYC - 1);
  localparam logic [16:0] AlignLimit = 17'(ALIGN_TIMEOUT_DWORDS);
  localparam logic [5:0] BlankCyc = 6'(`HPI_ALIGN_BLANK_CYC);
  localparam logic [1:0] RunLast = 2'(`HPI_NON_ALIGN_RUN - 1);
  localparam logic [1:0] RateLast = 2'(`HPI_NUM_RATES - 1);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic cominit_s;
  logic comwake_s;
  logic comma_s;
  logic cal_done_s;
  logic speed_done_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta_q <= 5'h00;
      pin_sync_q <= 5'h00;
    end else begin
      pin_meta_q <= {speed_done_pin, cal_done_pin, comma_det_pin, comwake_det_pin,
                     cominit_det_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign cominit_s = pin_sync_q[0];
  assign comwake_s = pin_sync_q[1];
  assign comma_s = pin_sync_q[2];
  assign cal_done_s = pin_sync_q[3];
  assign speed_done_s = pin_sync_q[4];

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic at_limit(input logic [16:0] cnt, input logic [16:0] lim);
    at_limit = (cnt >= lim);
  endfunction : at_limit

  hpi_state_e state_q;
  hpi_state_e state_d;
  logic entering;
  logic reset_in;
  logic wake_done;
  logic wake_busy;
  logic reset_busy;
  logic timeout;
  logic align_seen;
  logic run_done;
  logic halt_q;
  logic dword_tick;
  logic [2:0] dword_div_q;
  logic [16:0] dword_cnt_q;
  logic [5:0] blank_q;
  logic [1:0] run_q;

  assign reset_in = por_active | reset_request;
  assign entering = (state_d != state_q);

  // --------------------------------------------------------------------------
  // Out-of-band burst groups
  // --------------------------------------------------------------------------
  hpi_oob_burst #(
    .GAP_CYC(`HPI_RESET_GAP_CYC)
  ) u_reset_burst (
    .core_clk(core_clk),
    .rst(rst),
    .start(state_q == HOST_RESET_STATE || state_d == HOST_RESET_STATE),
    .hold(state_q == HOST_RESET_STATE),
    .burst_on(tx_comreset_burst),
    .busy(reset_busy),
    .done()
  );

  hpi_oob_burst #(
    .GAP_CYC(`HPI_WAKE_GAP_CYC)
  ) u_wake_burst (
    .core_clk(core_clk),
    .rst(rst),
    .start(entering && state_d == HOST_SEND_WAKE_STATE),
    .hold(1'b0),
    .burst_on(tx_comwake_burst),
    .busy(wake_busy),
    .done(wake_done)
  );

  // --------------------------------------------------------------------------
  // Dword divider and align timeout
  // --------------------------------------------------------------------------
  assign dword_tick = (dword_div_q == DwordLast);

  always_ff @(posedge core_clk) begin
    if (rst || state_q != HOST_WAIT_ALIGN_STATE) begin
      dword_div_q <= 3'h0;
    end else begin
      dword_div_q <= dword_tick ? 3'h0 : dword_div_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state_q != HOST_WAIT_ALIGN_STATE) begin
      dword_cnt_q <= 17'h00000;
    end else if (dword_tick && !at_limit(dword_cnt_q, AlignLimit)) begin
      dword_cnt_q <= dword_cnt_q + 17'h00001;
    end
  end

  assign timeout = at_limit(dword_cnt_q, AlignLimit);

  // Blanking window after wake release against crosstalk
  always_ff @(posedge core_clk) begin
    if (rst || state_q != HOST_WAIT_ALIGN_STATE) begin
      blank_q <= 6'h00;
    end else if (blank_q != BlankCyc) begin
      blank_q <= blank_q + 6'h01;
    end
  end

  assign align_seen = comma_s && (blank_q == BlankCyc);

  // --------------------------------------------------------------------------
  // Non-align run counter
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || state_q != HOST_SEND_ALIGN_STATE) begin
      run_q <= 2'h0;
    end else if (prim_valid) begin
      run_q <= prim_non_align ? ((run_q == RunLast) ? run_q : run_q + 2'h1) : 2'h0;
    end
  end

  assign run_done = prim_valid && prim_non_align && (run_q == RunLast);

  // --------------------------------------------------------------------------
  // Retry halt and rate stepping
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || reset_in) begin
      halt_q <= 1'b0;
    end else if (state_q == HOST_WAIT_ALIGN_STATE && timeout && !align_seen
                 && retry_disable) begin
      halt_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || por_active) begin
      rx_rate_sel <= 2'h0;
    end else if (state_q == HOST_WAIT_ALIGN_STATE && timeout && !align_seen) begin
      rx_rate_sel <= (rx_rate_sel == RateLast) ? 2'h0 : rx_rate_sel + 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (reset_in) begin
      state_d = HOST_RESET_STATE;
    end else if (cominit_s) begin
      state_d = HOST_WAIT_INIT_RELEASE_STATE;
    end else begin
      case (state_q)
        HOST_RESET_STATE: begin
          if (!halt_q) begin
            state_d = HOST_WAIT_INIT_STATE;
          end
        end
        HOST_WAIT_INIT_STATE: begin
          state_d = HOST_WAIT_INIT_STATE;
        end
        HOST_WAIT_INIT_RELEASE_STATE: begin
          state_d = cal_enable ? HOST_CALIBRATE_STATE
                               : HOST_SEND_WAKE_STATE;
        end
        HOST_CALIBRATE_STATE: begin
          if (!cal_enable || cal_done_s) begin
            state_d = HOST_SEND_WAKE_STATE;
          end
        end
        HOST_SEND_WAKE_STATE: begin
          if (wake_done) begin
            state_d = comwake_s ? HOST_WAIT_WAKE_RELEASE_STATE
                                : HOST_WAIT_WAKE_STATE;
          end
        end
        HOST_WAIT_WAKE_STATE: begin
          if (comwake_s) begin
            state_d = HOST_WAIT_WAKE_RELEASE_STATE;
          end
        end
        HOST_WAIT_WAKE_RELEASE_STATE: begin
          if (!comwake_s) begin
            state_d = HOST_WAIT_ALIGN_STATE;
          end
        end
        HOST_WAIT_ALIGN_STATE: begin
          if (align_seen) begin
            state_d = HOST_SPEED_ADJUST_STATE;
          end else if (timeout) begin
            state_d = HOST_RESET_STATE;
          end
        end
        HOST_SPEED_ADJUST_STATE: begin
          if (speed_done_s) begin
            state_d = HOST_SEND_ALIGN_STATE;
          end
        end
        HOST_SEND_ALIGN_STATE: begin
          if (run_done) begin
            state_d = HOST_READY_STATE;
          end
        end
        HOST_READY_STATE: begin
          state_d = HOST_READY_STATE;
        end
        default: state_d = HOST_RESET_STATE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= HOST_RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_filler <= 1'b0;
      tx_low_rate <= 1'b1;
      tx_align <= 1'b0;
      cal_start <= 1'b0;
      speed_adjust <= 1'b0;
      link_ready <= 1'b0;
      link_failed <= 1'b0;
      state_out <= 4'h0;
    end else begin
      tx_filler <= (state_d == HOST_WAIT_ALIGN_STATE);
      tx_low_rate <= (state_d != HOST_SEND_ALIGN_STATE && state_d != HOST_READY_STATE);
      tx_align <= (state_d == HOST_SEND_ALIGN_STATE);
      cal_start <= (state_d == HOST_CALIBRATE_STATE) && cal_enable;
      speed_adjust <= (state_d == HOST_SPEED_ADJUST_STATE);
      link_ready <= (state_d == HOST_READY_STATE);
      link_failed <= halt_q;
      state_out <= state_d;
    end
  end

endmodule : hpi_init_fsm

// file: testbench/hpi_init_fsm_assertions.sv
// Assertion checker for the host link initialisation block
`timescale 1ns/100ps

module hpi_init_fsm_assertions #(
  parameter int ALIGN_TIMEOUT_DWORDS = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Controls
  input wire logic por_active,
  input wire logic reset_request,
  input wire logic retry_disable,
  input wire logic cal_enable,
  // Drive pins
  input wire logic cominit_det_pin,
  input wire logic comwake_det_pin,
  // Outputs
  input wire logic tx_comreset_burst,
  input wire logic tx_comwake_burst,
  input wire logic tx_filler,
  input wire logic tx_low_rate,
  input wire logic [3:0] state_out
);
  localparam int LIM = ALIGN_TIMEOUT_DWORDS * 7;
  logic [2:0] grp_q;
  logic [7:0] gap_q;
  int w_q;
  wire rst_any = por_active || reset_request;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      grp_q <= 3'h0;
      gap_q <= 8'h1;
    end else if (tx_comreset_burst && gap_q != 8'h0) begin
      grp_q <= (grp_q == 3'h5) ? 3'h0 : grp_q + 3'h1;
      gap_q <= 8'h0;
    end else if (!tx_comreset_burst && gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state_out != 4'h7) begin
      w_q <= 0;
    end else begin
      w_q <= w_q + 1;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  sequence init_held_s;
    (cominit_det_pin && !rst_any)[*4];
  endsequence

  sequence wake_fall_s;
    state_out == 4'h6 && $fell(comwake_det_pin);
  endsequence

  cominit_jump_a: assert property (
    init_held_s |=> state_out == 4'h2)
    else $error("drive init did not force init release wait");
  reset_wins_a: assert property (
    rst_any |=> state_out == 4'h0)
    else $error("reset input did not force reset state");
  leave_reset_a: assert property (
    state_out == 4'h0 && !rst_any && !retry_disable |=> state_out inside {4'h1, 4'h2})
    else $error("reset state not left");
  burst_group_a: assert property (
    gap_q == 8'h64 |-> grp_q == 3'h0)
    else $error("reset bursts not a whole group");
  quiet_line_a: assert property (
    state_out inside {4'h1, 4'h2, 4'h5} && $stable(state_out)
    |-> !tx_comwake_burst && !tx_filler)
    else $error("line not quiet while waiting");
  cal_bypass_a: assert property (
    $past(state_out) == 4'h2 && state_out != 4'h2
    && !$past(cal_enable) && !rst_any |-> state_out == 4'h4)
    else $error("bypassed calibration not skipped");
  filler_low_a: assert property (
    state_out == 4'h7 && $stable(state_out) |-> tx_filler && tx_low_rate)
    else $error("filler not sent at low rate");
  wake_release_a: assert property (
    wake_fall_s |-> ##[1:133] tx_filler)
    else $error("filler late after wake release");
  align_blank_a: assert property (
    state_out == 4'h7 && w_q < 26 |=> state_out != 4'h8)
    else $error("align taken inside blank time");
  timeout_early_a: assert property (
    state_out == 4'h7 && w_q < LIM - 4 && !rst_any |=> state_out != 4'h0)
    else $error("align wait ended early");
  timeout_late_a: assert property (
    state_out == 4'h7 |-> w_q <= LIM + 4)
    else $error("align wait overran");
endmodule : hpi_init_fsm_assertions

bind hpi_init_fsm hpi_init_fsm_assertions #(
  .ALIGN_TIMEOUT_DWORDS(ALIGN_TIMEOUT_DWORDS)
) i_chk (
  .core_clk, .rst, .por_active, .reset_request, .retry_disable, .cal_enable,
  .cominit_det_pin, .comwake_det_pin, .tx_comreset_burst, .tx_comwake_burst,
  .tx_filler, .tx_low_rate, .state_out
);

// file: testbench/hpi_drive_model.sv
// Behavioural model of the attached drive's out-of-band signalling
`timescale 1ns/100ps

module hpi_drive_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host transmit side
  input wire logic tx_comreset_burst,
  input wire logic tx_comwake_burst,
  input wire logic tx_filler,
  // Scenario controls
  input wire logic mute,
  input wire logic early,
  input wire logic force_init,
  input wire logic [7:0] align_dly,
  // Drive signalling
  output logic cominit_det_pin,
  output logic comwake_det_pin,
  output logic comma_det_pin
);
  logic [7:0] rs_q;
  logic [7:0] wk_q;
  logic [7:0] fl_q;

  // Idle time since the last host burst, and time spent sending filler
  always_ff @(posedge core_clk) begin
    rs_q <= rst ? 8'hff : tx_comreset_burst ? 8'h0 : rs_q + {7'h0, rs_q != 8'hff};
    wk_q <= rst ? 8'hff : tx_comwake_burst ? 8'h0 : wk_q + {7'h0, wk_q != 8'hff};
    fl_q <= !tx_filler ? 8'h0 : fl_q + {7'h0, fl_q != 8'hff};
  end

  assign cominit_det_pin = force_init || (!mute && rs_q >= 8'h64 && rs_q < 8'h8c);
  assign comwake_det_pin = early ? wk_q < 8'h64 : (wk_q >= 8'h3c && wk_q < 8'ha0);
  // Characters start a while after wake release
  assign comma_det_pin = !mute && tx_filler && fl_q >= align_dly;
endmodule : hpi_drive_model

// file: testbench/hpi_init_fsm_test.sv
// Self-checking bench for the host link initialisation block
`timescale 1ns/100ps

module hpi_init_fsm_test;
  localparam int TO_DW = 20;
  logic core_clk, rst, por_active, reset_request, retry_disable, cal_enable;
  logic prim_valid, prim_non_align, cal_done_pin, speed_done_pin;
  logic mute, early, force_init;
  logic [7:0] align_dly;
  logic cominit_det_pin, comwake_det_pin, comma_det_pin;
  logic tx_comreset_burst, tx_comwake_burst, tx_filler, tx_low_rate, tx_align;
  logic cal_start, speed_adjust, link_ready, link_failed;
  logic [1:0] rx_rate_sel;
  logic [3:0] state_out, last_state;
  logic [3:0] exp_q[$];
  logic [31:0] rng;
  int mismatches, num_checks;

  hpi_init_fsm #(.ALIGN_TIMEOUT_DWORDS(TO_DW)) i_dut (
    .core_clk, .rst, .por_active, .reset_request, .retry_disable, .cal_enable,
    .prim_valid, .prim_non_align, .cominit_det_pin, .comwake_det_pin, .comma_det_pin,
    .cal_done_pin, .speed_done_pin, .tx_comreset_burst, .tx_comwake_burst, .tx_filler,
    .tx_low_rate, .tx_align, .cal_start, .speed_adjust, .rx_rate_sel, .link_ready,
    .link_failed, .state_out
  );

  hpi_drive_model i_drive (
    .core_clk, .rst, .tx_comreset_burst, .tx_comwake_burst, .tx_filler, .mute,
    .early, .force_init, .align_dly, .cominit_det_pin, .comwake_det_pin, .comma_det_pin
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic check_state(input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value state expected %h seen %h", e, g);
    end
  endtask : check_state

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cycles

  task automatic plan(input logic [47:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(s[i*4 +: 4]);
  endtask : plan

  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    while (state_out !== s && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_state

  // Every state change is matched against the oldest planned state
  always @(negedge core_clk) begin
    if (!rst && state_out !== last_state) begin
      if (exp_q.size() == 0) check_state(last_state, state_out);
      else check_state(exp_q.pop_front(), state_out);
    end
    last_state = state_out;
  end

  initial begin
    {por_active, reset_request, retry_disable, prim_valid, prim_non_align} = 5'h0;
    {cal_done_pin, speed_done_pin, mute, early, force_init} = 5'h0;
    cal_enable = 1'b1;
    align_dly = 8'h5;
    rng = 32'h15845;
    mismatches = 0;
    num_checks = 0;
    rst = 1'b1;
    cycles(8);
    rst = 1'b0;
    // ----------------------------------------------------------------------
    // Bring-up with calibration and early comma
    // ----------------------------------------------------------------------
    plan(48'h123456789, 9);
    wait_state(4'h3);
    cycles(1);
    check_bit("cal_start", 1'b1, cal_start);
    rng = xs(rng);
    cycles(int'(rng[5:0]) + 2);
    cal_done_pin = 1'b1;
    wait_state(4'h4);
    cal_done_pin = 1'b0;
    wait_state(4'h7);
    cycles(1);
    check_bit("tx_filler", 1'b1, tx_filler);
    wait_state(4'h8);
    cycles(1);
    check_bit("speed_adjust", 1'b1, speed_adjust);
    rng = xs(rng);
    cycles(int'(rng[4:0]) + 1);
    speed_done_pin = 1'b1;
    wait_state(4'h9);
    speed_done_pin = 1'b0;
    cycles(1);
    check_bit("tx_align", 1'b1, tx_align);
    check_bit("tx_low_rate", 1'b0, tx_low_rate);
    // Align in mid-run restarts the count of three
    prim_valid = 1'b1;
    for (int i = 5; i >= 0; i--) begin
      prim_non_align = i != 3;
      if (i == 0) exp_q.push_back(4'ha);
      @(negedge core_clk);
    end
    prim_valid = 1'b0;
    wait_state(4'ha);
    cycles(1);
    check_bit("link_ready", 1'b1, link_ready);
    // ----------------------------------------------------------------------
    // Drive init from ready, bypass, early wake, silent drive
    // ----------------------------------------------------------------------
    cal_enable = 1'b0;
    early = 1'b1;
    mute = 1'b1;
    align_dly = 8'h3c;
    plan(48'h24670124678, 11);
    force_init = 1'b1;
    cycles(6);
    force_init = 1'b0;
    wait_state(4'h0);
    cycles(1);
    check_bit("rate_step", 1'b1, rx_rate_sel === 2'h1);
    mute = 1'b0;
    wait_state(4'h8);
    // ----------------------------------------------------------------------
    // Reset request beats drive init, then retries disabled
    // ----------------------------------------------------------------------
    reset_request = 1'b1;
    plan(48'h0, 1);
    cycles(3);
    force_init = 1'b1;
    cycles(10);
    force_init = 1'b0;
    cycles(20);
    check_bit("held_reset", 1'b1, state_out === 4'h0);
    {retry_disable, cal_done_pin, cal_enable, early} = 4'he;
    plan(48'h12345670, 8);
    reset_request = 1'b0;
    wait_state(4'h4);
    mute = 1'b1;
    wait_state(4'h7);
    wait_state(4'h0);
    cycles(2);
    check_bit("link_failed", 1'b1, link_failed);
    check_bit("rate_step", 1'b1, rx_rate_sel === 2'h2);
    por_active = 1'b1;
    cycles(2);
    check_bit("rate_clear", 1'b1, rx_rate_sel === 2'h0);
    check_bit("link_failed", 1'b0, link_failed);
    plan(48'h1, 1);
    por_active = 1'b0;
    cycles(5);
    check_bit("plan_done", 1'b1, exp_q.size() == 0);
    tally_and_finish();
  end
endmodule : hpi_init_fsm_test
